// file: inc/safety_monitor_map.vh
// constants of the drive safety monitor: register map, fields, timing
// assumes a 100 MHz clock and a 32-bit ahb-lite register bus
`ifndef SAFETY_MONITOR_MAP_VH
`define SAFETY_MONITOR_MAP_VH

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_EMU_PERIODS 8'h08
`define REG_FILTER_HZ 8'h0c
`define REG_MULTITURN 8'h10
`define REG_FILT_SPEED 8'h14
`define REG_FAULT_CODE 8'h18
`define REG_PROFILE 8'h1c

`define CTRL_COUPLE_BIT 0
`define CTRL_CARD_BIT 1
`define CTRL_ACK_BIT 2
`define CTRL_RESET 2'h2

`define EMU_PERIODS_RESET 16'h0800
`define FILTER_HZ_RESET 7'h4b
`define FILTER_HZ_MAX 7'h4b
`define FILTER_SHIFT 8

`define PROFILE_VERSION_OK 8'h26
`define PROFILE_CRC_OK 3'h4

`define FAULT_CODE_NONE 8'h00
`define FAULT_CODE_TORQUE_OFF 8'h01
`define FAULT_CODE_DISCREPANCY 8'h02
`define FAULT_CODE_INTERNAL 8'h03

`define DISCREPANCY_MS 1000
`define CLOCK_KHZ 100000

`define HTRANS_NONSEQ 2'h2

`endif

// file: logic/drive_safety_monitor.v
// safety monitor of a servo drive safety card with ahb-lite registers
// assumes synchronous inputs from a safety controller and one clock
`timescale 1ns/1ps
`include "safety_monitor_map.vh"

module drive_safety_monitor #(
  parameter POS_W = 16,
  parameter SPEED_W = 16,
  parameter DISC_CYCLES = `DISCREPANCY_MS * `CLOCK_KHZ
)
(
  input wire clock_i,
  input wire sys_rst_i,
  input wire torque_off_channel_a_i,
  input wire torque_off_channel_b_i,
  input wire torque_off_return_input_i,
  input wire card_reset_i,
  input wire drive_enabled_i,
  input wire drive_in_control_i,
  input wire internal_fault_i,
  input wire [POS_W-1:0] safe_position_i,
  input wire signed [SPEED_W-1:0] safe_speed_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  output reg torque_off_diag_o,
  output reg torque_enable_o,
  output reg safe_brake_control_o,
  output reg card_status_o,
  output reg torque_fault_o,
  output reg emu_enable_o,
  output reg signed [7:0] emu_sine_o,
  output reg signed [7:0] emu_cosine_o
);

  localparam ST_INIT = 4'b0001;
  localparam ST_NORMAL = 4'b0010;
  localparam ST_SAFE = 4'b0100;
  localparam ST_FAULT = 4'b1000;
  localparam [1:0] CTRL_RST = `CTRL_RESET;

  reg [3:0] state;
  reg [3:0] next_state;
  reg couple_brake_to_torque_off;
  reg card_fitted;
  reg [15:0] emu_periods;
  reg [6:0] filter_hz;
  reg [7:0] profile_version;
  reg [2:0] profile_crc;
  reg profile_accept;
  reg [7:0] torque_off_fault_code;
  reg [15:0] multiturn;
  reg signed [SPEED_W+7:0] filt_acc;
  reg [31:0] disc_count;
  reg disc_fault;
  reg sto_prev;
  reg reset_prev;
  reg [POS_W-1:0] pos_prev;
  reg wr_pend;
  reg [7:0] wr_addr;
  reg fault_ack;
  wire safe_torque_off;
  wire sto_rise;
  wire reset_rise;
  wire channels_agree;
  wire [31:0] phase_full;
  wire [15:0] phase;
  wire signed [SPEED_W+7:0] speed_ext;
  wire signed [SPEED_W+7:0] filt_err;
  wire signed [SPEED_W+15:0] filt_step;
  wire [6:0] alpha;
  wire addr_ok;

  // triangle approximation of a sine over one period
  function [7:0] tri_wave;
    input [15:0] ph;
    reg [7:0] m;
    begin
      m = {1'b0, ph[13:7]};
      case (ph[15:14])
        2'b00: tri_wave = m;
        2'b01: tri_wave = 8'h7f - m;
        2'b10: tri_wave = 8'h00 - m;
        default: tri_wave = m - 8'h7f;
      endcase
    end
  endfunction

  // card fitted: two channels; basic device: input and return
  assign safe_torque_off = card_fitted ?
    (~torque_off_channel_a_i | ~torque_off_channel_b_i) :
    (~torque_off_channel_a_i | ~torque_off_return_input_i);
  assign sto_rise = safe_torque_off & ~sto_prev;
  assign reset_rise = card_reset_i & ~reset_prev;
  assign channels_agree = torque_off_channel_a_i == torque_off_channel_b_i;
  assign phase_full = safe_position_i * emu_periods;
  assign phase = phase_full[15:0];
  assign alpha = (filter_hz > `FILTER_HZ_MAX) ? `FILTER_HZ_MAX : filter_hz;
  assign speed_ext = {safe_speed_i, 8'h00};
  assign filt_err = speed_ext - filt_acc;
  assign filt_step = filt_err * $signed({1'b0, alpha});
  assign addr_ok = hsel_i & hready_i & (htrans_i == `HTRANS_NONSEQ);

  // discrepancy timer between the two channels
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      disc_count <= 32'h0000_0000;
      disc_fault <= 1'b0;
    end
    else if (!card_fitted || channels_agree)
    begin
      disc_count <= 32'h0000_0000;
      disc_fault <= 1'b0;
    end
    else
    begin
      // saturates so a long mismatch never wraps
      if (disc_count < DISC_CYCLES)
        disc_count <= disc_count + 32'h0000_0001;
      disc_fault <= (disc_count >= DISC_CYCLES);
    end
  end

  // card state machine
  always @*
  begin
    next_state = state;
    case (state)
      ST_INIT:
      begin
        if (reset_rise)
          next_state = ST_NORMAL;
      end
      ST_NORMAL:
      begin
        if (safe_torque_off)
          next_state = ST_SAFE;
      end
      ST_SAFE:
      begin
        if (!safe_torque_off)
          next_state = ST_NORMAL;
      end
      ST_FAULT:
      begin
        if (reset_rise && channels_agree && !internal_fault_i)
          next_state = ST_NORMAL;
      end
      default: next_state = ST_INIT;
    endcase
    if (card_fitted && (disc_fault || internal_fault_i))
      next_state = ST_FAULT;
  end

  always @(posedge clock_i)
  begin
    if (sys_rst_i)
      state <= ST_INIT;
    else
      state <= next_state;
  end

  // torque-off fault, brake coupling and diagnostics
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      sto_prev <= 1'b1;
      reset_prev <= 1'b1;
      torque_fault_o <= 1'b0;
      torque_off_fault_code <= `FAULT_CODE_NONE;
      torque_off_diag_o <= 1'b1;
      safe_brake_control_o <= 1'b0;
      torque_enable_o <= 1'b0;
      card_status_o <= 1'b0;
    end
    else
    begin
      sto_prev <= safe_torque_off;
      reset_prev <= card_reset_i;
      // set wins over acknowledge; no fault once enable removed
      if (sto_rise && drive_enabled_i && drive_in_control_i)
      begin
        torque_fault_o <= 1'b1;
        torque_off_fault_code <= `FAULT_CODE_TORQUE_OFF;
      end
      else if (card_fitted && state[3] && internal_fault_i)
        torque_off_fault_code <= `FAULT_CODE_INTERNAL;
      else if (card_fitted && state[3] && disc_fault)
        torque_off_fault_code <= `FAULT_CODE_DISCREPANCY;
      else if (fault_ack)
      begin
        torque_fault_o <= 1'b0;
        torque_off_fault_code <= `FAULT_CODE_NONE;
      end
      torque_off_diag_o <= safe_torque_off;
      safe_brake_control_o <= couple_brake_to_torque_off &
        safe_torque_off;
      torque_enable_o <= ~safe_torque_off & ~torque_fault_o &
        (~card_fitted | state[1]) & drive_enabled_i &
        drive_in_control_i;
      card_status_o <= card_fitted ? (state[1] | state[2]) : 1'b1;
    end
  end

  // sine/cosine emulation
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      emu_enable_o <= 1'b0;
      emu_sine_o <= 8'sh00;
      emu_cosine_o <= 8'sh00;
    end
    else if (card_fitted && (state[1] || state[2]))
    begin
      emu_enable_o <= 1'b1;
      emu_sine_o <= tri_wave(phase);
      emu_cosine_o <= tri_wave(phase + 16'h4000);
    end
    else
    begin
      emu_enable_o <= 1'b0;
      emu_sine_o <= 8'sh00;
      emu_cosine_o <= 8'sh00;
    end
  end

  // multiturn counter from singleturn wrap
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      multiturn <= 16'h0000;
      pos_prev <= {POS_W{1'b0}};
    end
    else
    begin
      pos_prev <= safe_position_i;
      if (pos_prev[POS_W-1:POS_W-2] == 2'b11 &&
          safe_position_i[POS_W-1:POS_W-2] == 2'b00)
        multiturn <= multiturn + 16'h0001;
      else if (pos_prev[POS_W-1:POS_W-2] == 2'b00 &&
               safe_position_i[POS_W-1:POS_W-2] == 2'b11)
        multiturn <= multiturn - 16'h0001;
    end
  end

  // first-order low-pass on safe speed
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
      filt_acc <= {(SPEED_W+8){1'b0}};
    else
      filt_acc <= filt_acc +
        filt_step[SPEED_W+7+`FILTER_SHIFT:`FILTER_SHIFT];
  end

  // ahb-lite slave: write in data phase, read data registered
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      fault_ack <= 1'b0;
      couple_brake_to_torque_off <= CTRL_RST[`CTRL_COUPLE_BIT];
      card_fitted <= CTRL_RST[`CTRL_CARD_BIT];
      emu_periods <= `EMU_PERIODS_RESET;
      filter_hz <= `FILTER_HZ_RESET;
      profile_version <= 8'h00;
      profile_crc <= 3'h0;
      profile_accept <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      fault_ack <= 1'b0;
      wr_pend <= addr_ok & hwrite_i;
      wr_addr <= haddr_i[7:0];
      if (wr_pend)
      begin
        case (wr_addr)
          `REG_CTRL:
          begin
            couple_brake_to_torque_off <= hwdata_i[`CTRL_COUPLE_BIT];
            card_fitted <= hwdata_i[`CTRL_CARD_BIT];
            fault_ack <= hwdata_i[`CTRL_ACK_BIT];
          end
          `REG_EMU_PERIODS: emu_periods <= hwdata_i[15:0];
          `REG_FILTER_HZ:
          begin
            if (hwdata_i[6:0] > `FILTER_HZ_MAX)
              filter_hz <= `FILTER_HZ_MAX;
            else
              filter_hz <= hwdata_i[6:0];
          end
          `REG_PROFILE:
          begin
            profile_version <= hwdata_i[7:0];
            profile_crc <= hwdata_i[10:8];
            profile_accept <= (hwdata_i[7:0] == `PROFILE_VERSION_OK) &&
              (hwdata_i[10:8] == `PROFILE_CRC_OK);
          end
          default: ;
        endcase
      end
      if (addr_ok && !hwrite_i)
      begin
        case (haddr_i[7:0])
          `REG_CTRL: hrdata_o <= {30'h0, card_fitted,
            couple_brake_to_torque_off};
          `REG_STATUS: hrdata_o <= {22'h0, profile_accept, disc_fault,
            torque_fault_o, emu_enable_o, safe_brake_control_o,
            torque_off_diag_o, state};
          `REG_EMU_PERIODS: hrdata_o <= {16'h0, emu_periods};
          `REG_FILTER_HZ: hrdata_o <= {25'h0, filter_hz};
          `REG_MULTITURN: hrdata_o <= {16'h0, multiturn};
          `REG_FILT_SPEED: hrdata_o <= {{(32-SPEED_W){filt_acc[SPEED_W+7]}},
            filt_acc[SPEED_W+7:8]};
          `REG_FAULT_CODE: hrdata_o <= {24'h0, torque_off_fault_code};
          `REG_PROFILE: hrdata_o <= {21'h0, profile_crc, profile_version};
          default: hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // drive_safety_monitor

// file: bench/drive_safety_monitor_props.sv
// checker of monitor outputs against channel and fault inputs
// assumes binding onto drive_safety_monitor, one clock domain
`timescale 1ns/1ps
module drive_safety_monitor_props #(
  parameter DISC_CYCLES = 20
)
(
  input wire clock_i,
  input wire sys_rst_i,
  input wire torque_off_channel_a_i,
  input wire torque_off_channel_b_i,
  input wire drive_enabled_i,
  input wire internal_fault_i,
  input wire torque_off_diag_o,
  input wire torque_enable_o,
  input wire safe_brake_control_o,
  input wire card_status_o,
  input wire torque_fault_o,
  input wire emu_enable_o,
  input wire signed [7:0] emu_sine_o,
  input wire signed [7:0] emu_cosine_o
);
  int cnt;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  // cycles the channels have disagreed
  always @(posedge clock_i)
  begin
    if (sys_rst_i || torque_off_channel_a_i == torque_off_channel_b_i)
      cnt <= 0;
    else if (cnt < DISC_CYCLES + 6)
      cnt <= cnt + 1;
  end
  a_diag_on_loss: assert property (
    !torque_off_channel_a_i |=> torque_off_diag_o)
    else $error("diag low after channel loss");
  a_brake_with_sto: assert property (
    safe_brake_control_o |-> torque_off_diag_o)
    else $error("brake without torque-off");
  a_torque_blocked: assert property (
    torque_off_diag_o |-> !torque_enable_o)
    else $error("torque allowed during torque-off");
  a_emu_zero: assert property (
    !emu_enable_o |-> emu_sine_o == 0 && emu_cosine_o == 0)
    else $error("emulation not zero when off");
  a_emu_fault_off: assert property (
    internal_fault_i && emu_enable_o |-> ##[1:3] !emu_enable_o)
    else $error("emulation on after internal fault");
  a_no_fault_idle: assert property (
    $rose(torque_fault_o) |->
      $past(drive_enabled_i) || $past(drive_enabled_i, 2))
    else $error("fault set with drive disabled");
  a_emu_ready: assert property (
    emu_enable_o |-> card_status_o)
    else $error("emulation on while card not ready");
  a_disc_fault: assert property (
    cnt == DISC_CYCLES + 6 |-> !card_status_o)
    else $error("no fault after discrepancy");
endmodule // drive_safety_monitor_props
bind drive_safety_monitor drive_safety_monitor_props #(
  .DISC_CYCLES(DISC_CYCLES)
) drive_safety_monitor_props_i (.*);

// file: bench/ctl_model.sv
// controller model: channels, card reset, enables, vector check
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/1ps
module ctl_model #(
  parameter LEN_MIN = 9'h040
)
(
  input wire clock_i,
  input wire signed [7:0] sine_i,
  input wire signed [7:0] cosine_i,
  input wire emu_on_i,
  output reg chan_a_o,
  output reg chan_b_o,
  output reg card_reset_o,
  output reg enable_o,
  output reg control_o,
  output wire vector_bad_o
);
  function [8:0] mag(input [7:0] v);
    mag = v[7] ? 9'h000 - {1'b1, v} : {1'b0, v};
  endfunction
  assign vector_bad_o = emu_on_i &&
    (mag(sine_i) + mag(cosine_i) < LEN_MIN);
  initial
  begin
    chan_a_o = 1'b0;
    chan_b_o = 1'b0;
    card_reset_o = 1'b0;
    enable_o = 1'b0;
    control_o = 1'b0;
  end
  task set_ch(input a, input b);
  begin
    chan_a_o <= a;
    chan_b_o <= b;
  end
  endtask
  task set_drv(input e, input c);
  begin
    enable_o <= e;
    control_o <= c;
  end
  endtask
  task pulse;
  begin
    card_reset_o <= 1'b1;
    repeat (2) @(posedge clock_i);
    card_reset_o <= 1'b0;
  end
  endtask
  task stop_then_sto;
  begin
    set_drv(1'b0, 1'b0);
    repeat (4) @(posedge clock_i);
    set_ch(1'b0, 1'b0);
  end
  endtask
endmodule // ctl_model

// file: bench/drive_safety_monitor_tb.sv
// bench of the safety monitor: bus master, position, speed
// assumes ctl_model for channel and enable inputs
`timescale 1ns/1ps
module drive_safety_monitor_tb;
  localparam D = 20;
  reg clock_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg ifault = 1'b0;
  reg ret = 1'b1;
  reg [15:0] pos = 16'h0000;
  reg signed [15:0] spd = 16'h0000;
  reg hsel = 1'b0;
  reg hwr = 1'b0;
  reg [1:0] htr = 2'h0;
  reg [31:0] ha = 32'h0;
  reg [31:0] hwd = 32'h0;
  reg [31:0] q;
  reg [31:0] p;
  wire [31:0] hrd;
  wire rdy, resp, a, b, cr, en, ctl, bad, diag, ten, brk, stat, tf, emen;
  wire signed [7:0] sn;
  wire signed [7:0] cs;
  integer n_fail = 0;
  integer n_checks = 0;
  always #5 clock_i = ~clock_i;
  drive_safety_monitor #(.DISC_CYCLES(D)) drive_safety_monitor_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .torque_off_channel_a_i(a), .torque_off_channel_b_i(b),
    .torque_off_return_input_i(ret), .card_reset_i(cr),
    .drive_enabled_i(en), .drive_in_control_i(ctl),
    .internal_fault_i(ifault), .safe_position_i(pos),
    .safe_speed_i(spd), .hsel_i(hsel), .haddr_i(ha),
    .htrans_i(htr), .hwrite_i(hwr), .hsize_i(3'h2),
    .hwdata_i(hwd), .hready_i(rdy), .hrdata_o(hrd),
    .hreadyout_o(rdy), .hresp_o(resp), .torque_off_diag_o(diag),
    .torque_enable_o(ten), .safe_brake_control_o(brk),
    .card_status_o(stat), .torque_fault_o(tf),
    .emu_enable_o(emen), .emu_sine_o(sn), .emu_cosine_o(cs));
  ctl_model ctl_model_i (.clock_i(clock_i), .sine_i(sn),
    .cosine_i(cs), .emu_on_i(emen), .chan_a_o(a), .chan_b_o(b),
    .card_reset_o(cr), .enable_o(en), .control_o(ctl),
    .vector_bad_o(bad));
  task close_out;
  begin
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task chk(input [31:0] e, input [31:0] s, input string nm);
  begin
    n_checks = n_checks + 1;
    if (s !== e)
    begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  task tk(input integer n);
    repeat (n) @(posedge clock_i);
  endtask
  task wt(input s);
    integer k;
  begin
    k = 0;
    @(posedge clock_i);
    while ((s ? rdy : stat) !== 1'b1 && k < 50)
    begin
      k = k + 1;
      @(posedge clock_i);
    end
    if (k == 50)
    begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  endtask
  task bus(input [7:0] ad, input w, input [31:0] d);
  begin
    @(posedge clock_i);
    hsel <= 1'b1;
    ha <= {24'h0, ad};
    htr <= 2'h2;
    hwr <= w;
    wt(1'b1);
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= d;
    wt(1'b1);
    q = hrd;
  end
  endtask
  task rc(input [7:0] ad, input [31:0] e, input string nm);
  begin
    bus(ad, 1'b0, 32'h0);
    chk(e, q, nm);
    chk(0, resp, "hresp");
  end
  endtask
  task t_start;
  begin
    rc(8'h08, 32'h800, "periods");
    rc(8'h10, 32'h0, "turns");
    rc(8'h40, 32'h0, "unmapped");
    chk(1, diag, "diag");
    chk(0, stat, "status");
    ctl_model_i.set_ch(1'b1, 1'b1);
    tk(2);
    chk(0, diag, "diag");
    ctl_model_i.pulse;
    wt(1'b0);
    chk(1, emen, "emu");
    bus(8'h04, 1'b0, 32'h0);
    chk(2, q[3:0], "state");
    $display("t_start done");
  end
  endtask
  task t_sto;
  begin
    bus(8'h00, 1'b1, 32'h3);
    ctl_model_i.set_drv(1'b1, 1'b1);
    tk(3);
    chk(1, ten, "torque");
    ctl_model_i.set_ch(1'b0, 1'b0);
    tk(3);
    chk(1, brk, "brake");
    chk(1, tf, "fault");
    rc(8'h18, 32'h1, "code");
    ctl_model_i.set_ch(1'b1, 1'b1);
    bus(8'h00, 1'b1, 32'h6);
    tk(2);
    chk(0, tf, "fault");
    ctl_model_i.stop_then_sto;
    tk(3);
    chk(0, tf, "fault");
    chk(0, brk, "brake");
    ctl_model_i.set_ch(1'b1, 1'b1);
    ctl_model_i.set_drv(1'b1, 1'b1);
    tk(3);
    chk(1, ten, "torque");
    $display("t_sto done");
  end
  endtask
  task t_disc;
  begin
    ctl_model_i.set_drv(1'b0, 1'b0);
    ctl_model_i.set_ch(1'b0, 1'b1);
    tk(D - 3);
    chk(1, stat, "status");
    chk(0, ten, "torque");
    tk(10);
    chk(0, stat, "status");
    rc(8'h18, 32'h2, "code");
    ctl_model_i.set_ch(1'b1, 1'b1);
    tk(2);
    ctl_model_i.pulse;
    wt(1'b0);
    $display("t_disc done");
  end
  endtask
  task t_turns;
  begin
    pos <= 16'hc000;
    tk(3);
    rc(8'h10, 32'hffff, "turns");
    pos <= 16'h0000;
    bus(8'h08, 1'b1, 32'h4);
    tk(3);
    rc(8'h10, 32'h0, "turns");
    p = cs;
    pos <= 16'h1000;
    tk(3);
    chk(p, sn, "sine");
    chk(0, bad, "vector");
    $display("t_turns done");
  end
  endtask
  task t_filt;
  begin
    bus(8'h0c, 1'b1, 32'hff);
    rc(8'h0c, 32'h4b, "hz");
    spd <= 16'sd100;
    tk(300);
    bus(8'h14, 1'b0, 32'h0);
    chk(1, q >= 98 && q <= 100, "speed");
    bus(8'h0c, 1'b1, 32'h0);
    p = q;
    spd <= -16'sd50;
    tk(50);
    rc(8'h14, p, "speed");
    bus(8'h1c, 1'b1, 32'h426);
    bus(8'h04, 1'b0, 32'h0);
    chk(1, q[9], "profile");
    bus(8'h1c, 1'b1, 32'h425);
    bus(8'h04, 1'b0, 32'h0);
    chk(0, q[9], "profile");
    $display("t_filt done");
  end
  endtask
  task t_int;
  begin
    ifault <= 1'b1;
    tk(4);
    chk(0, emen, "emu");
    chk(0, {sn, cs}, "sincos");
    rc(8'h18, 32'h3, "code");
    ifault <= 1'b0;
    ctl_model_i.pulse;
    wt(1'b0);
    $display("t_int done");
  end
  endtask
  task t_basic;
  begin
    bus(8'h00, 1'b1, 32'h0);
    ctl_model_i.set_drv(1'b1, 1'b1);
    tk(3);
    chk(1, stat, "status");
    chk(0, emen, "emu");
    chk(1, ten, "torque");
    ret <= 1'b0;
    tk(3);
    chk(1, diag, "diag");
    chk(0, ten, "torque");
    chk(1, tf, "fault");
    rc(8'h18, 32'h1, "code");
    ret <= 1'b1;
    bus(8'h00, 1'b1, 32'h4);
    tk(2);
    chk(0, tf, "fault");
    rc(8'h18, 32'h0, "code");
    chk(1, ten, "torque");
    $display("t_basic done");
  end
  endtask
  initial
  begin
    tk(4);
    sys_rst_i <= 1'b0;
    t_start;
    t_sto;
    t_disc;
    t_turns;
    t_filt;
    t_int;
    t_basic;
    close_out;
  end
endmodule // drive_safety_monitor_tb
